// *** rtl/bcec_pkg.sv ***
//////////////////////////////////////////////////////////////////////////////
// Purpose: constants and types of the bus command error checker
// Assumes: 250 MHz system clock, 32-bit classic wishbone register port
// Notes:   register offsets are byte addresses of aligned words
//////////////////////////////////////////////////////////////////////////////
package bcec_pkg;
  // register offsets
  localparam logic [7:0] ADR_ERR   = 8'h00;
  localparam logic [7:0] ADR_MASK  = 8'h04;
  localparam logic [7:0] ADR_CTRL  = 8'h08;
  localparam logic [7:0] ADR_VSRC  = 8'h0c;
  localparam logic [7:0] ADR_CAL   = 8'h10;
  localparam logic [7:0] ADR_STATE = 8'h14;
  // error_condition_word bit positions
  localparam int ERR_W   = 5;
  localparam int EB_ICMD = 0;
  localparam int EB_IOPT = 1;
  localparam int EB_NREM = 2;
  localparam int EB_TOVR = 3;
  localparam int EB_NUM  = 4;
  // control bit, reset values
  localparam int               CB_SLOW   = 0;
  localparam logic [ERR_W-1:0] ERR_RST   = 5'h00;
  localparam logic [ERR_W-1:0] MASK_RST  = 5'h00;
  localparam logic             SLOW_RST  = 1'b0;
  localparam logic [12:0]      VSRC_RST  = 13'h0000;
  localparam logic [15:0]      CAL_RST   = 16'h0000;
  // number limits, in 10 mV units for the source
  localparam logic [31:0] VNEG_MAX = 32'h000027fb;
  localparam logic [31:0] VPOS_MAX = 32'h00002800;
  localparam logic [31:0] VSTEP    = 32'h00000005;
  localparam logic [23:0] CAL_MAX  = 24'h00270f;
  localparam logic [23:0] MAG_OVF  = 24'h100000;
  // characters and command letters
  localparam logic [7:0] CH_X     = 8'h58;
  localparam logic [7:0] CH_DOT   = 8'h2e;
  localparam logic [7:0] CH_MINUS = 8'h2d;
  localparam logic [7:0] CH_PLUS  = 8'h2b;
  localparam logic [4:0] LET_V    = 5'h15;
  localparam logic [4:0] LET_C    = 5'h02;
  localparam logic [4:0] LET_T    = 5'h13;
  localparam int         NLET     = 26;
  // valid letters (bit = letter index, A = 0) and highest option per letter
  localparam logic [NLET-1:0] LET_VALID = 26'h23a402c;
  localparam logic [3:0] OPT_MAX [NLET] = '{4'h0, 4'h0, 4'h0, 4'h1, 4'h0, 4'h5, 4'h0,
    4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h1, 4'h0, 4'h0, 4'h9, 4'h0, 4'h7,
    4'h2, 4'h0, 4'h0, 4'h0, 4'h0, 4'h1};
  // timing
  localparam int CLK_KHZ  = 250000;
  localparam int DISP_MS  = 1000;
  localparam int FAST_MS  = 365;
  localparam int SLOW_MS  = 780;
  localparam int DISP_CYC = DISP_MS * CLK_KHZ;
  localparam int FAST_CYC = FAST_MS * CLK_KHZ;
  localparam int SLOW_CYC = SLOW_MS * CLK_KHZ;
  localparam int CNT_W    = 28;
  typedef enum logic [1:0] {
    MSG_NONE = 2'h0,
    MSG_BUS  = 2'h1,
    MSG_NUM  = 2'h2,
    MSG_TRIG = 2'h3
  } bcec_msg_t;
endpackage : bcec_pkg

// *** rtl/bcec_ctl_if.sv ***
//////////////////////////////////////////////////////////////////////////////
// Purpose: links the checker to its message timer and reading timer
// Assumes: single clock domain
// Notes:   show and trig are one-cycle pulses
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/10ps
interface bcec_ctl_if;
  logic                show;
  bcec_pkg::bcec_msg_t msg_req;
  logic                disp_on;
  bcec_pkg::bcec_msg_t msg;
  logic                trig;
  logic                slow;
  logic                busy;
  logic                ready;
  modport main (output show, msg_req, trig, slow, input disp_on, msg, busy, ready);
  modport disp (input show, msg_req, output disp_on, msg);
  modport rdy  (input trig, slow, output busy, ready);
endinterface : bcec_ctl_if

// *** rtl/bcec_msg_timer.sv ***
//////////////////////////////////////////////////////////////////////////////
// Purpose: holds a front panel message for a fixed time
// Assumes: show is a one-cycle pulse
// Notes:   a new message restarts the hold
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/10ps
module bcec_msg_timer #(
  parameter int unsigned HOLD_CYC = bcec_pkg::DISP_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  bcec_ctl_if.disp ctl
);
  import bcec_pkg::*;
  logic [CNT_W-1:0] cnt_q;
  bcec_msg_t        msg_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= '0;
      msg_q <= MSG_NONE;
    end else if (ctl.show) begin
      cnt_q <= HOLD_CYC[CNT_W-1:0];
      msg_q <= ctl.msg_req;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - {{(CNT_W-1){1'b0}}, 1'b1};
      if (cnt_q == {{(CNT_W-1){1'b0}}, 1'b1}) begin
        msg_q <= MSG_NONE;
      end
    end
  end

  assign ctl.msg     = msg_q;
  assign ctl.disp_on = (msg_q != MSG_NONE);
endmodule : bcec_msg_timer

// *** rtl/bcec_ready_timer.sv ***
//////////////////////////////////////////////////////////////////////////////
// Purpose: tracks a reading from trigger to reading-ready
// Assumes: trig only arrives while not busy
// Notes:   ready is a one-cycle pulse as busy falls
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/10ps
module bcec_ready_timer #(
  parameter int unsigned FAST_CYC = bcec_pkg::FAST_CYC,
  parameter int unsigned SLOW_CYC = bcec_pkg::SLOW_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  bcec_ctl_if.rdy  ctl
);
  import bcec_pkg::*;
  typedef enum logic [1:0] {
    RD_IDLE = 2'b01,
    RD_BUSY = 2'b10
  } bcec_rd_t;
  bcec_rd_t         st_q;
  logic [CNT_W-1:0] cnt_q;
  logic             rdy_q;
  wire              last = (cnt_q == {{(CNT_W-1){1'b0}}, 1'b1});

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q  <= RD_IDLE;
      cnt_q <= '0;
      rdy_q <= 1'b0;
    end else begin
      rdy_q <= 1'b0;
      case (st_q)
        RD_IDLE: begin
          if (ctl.trig) begin
            st_q  <= RD_BUSY;
            cnt_q <= ctl.slow ? SLOW_CYC[CNT_W-1:0] : FAST_CYC[CNT_W-1:0];
          end
        end
        RD_BUSY: begin
          cnt_q <= cnt_q - {{(CNT_W-1){1'b0}}, 1'b1};
          if (last) begin
            st_q  <= RD_IDLE;
            rdy_q <= 1'b1;
          end
        end
        default: st_q <= RD_IDLE;
      endcase
    end
  end

  assign ctl.busy  = (st_q == RD_BUSY);
  assign ctl.ready = rdy_q;
endmodule : bcec_ready_timer

// *** rtl/bcec_checker.sv ***
//////////////////////////////////////////////////////////////////////////////
// Purpose: checks command strings from the bus, keeps error word and timers
// Assumes: command characters arrive on the system clock, ren_i is a pin
// Notes:   settings commit only when the terminator arrives
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/10ps
module bcec_checker #(
  parameter int unsigned DISP_CYC = bcec_pkg::DISP_CYC,
  parameter int unsigned FAST_CYC = bcec_pkg::FAST_CYC,
  parameter int unsigned SLOW_CYC = bcec_pkg::SLOW_CYC
) (
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic [7:0]         adr_i,
  input  wire logic [31:0]        dat_i,
  output logic      [31:0]        dat_o,
  input  wire logic               we_i,
  input  wire logic [3:0]         sel_i,
  input  wire logic               cyc_i,
  input  wire logic               stb_i,
  output logic                    ack_o,
  input  wire logic               rx_valid_i,
  input  wire logic [7:0]         rx_char_i,
  input  wire logic               ren_i,
  input  wire logic               trig_i,
  output logic                    irq_o,
  output bcec_pkg::bcec_msg_t     disp_msg_o,
  output logic                    disp_on_o,
  output logic                    busy_o,
  output logic                    reading_ready_o,
  output logic signed [12:0]      vsrc_step_o,
  output logic      [15:0]        cal_val_o,
  output logic      [3:0]         trig_mode_o
);
  import bcec_pkg::*;

  bcec_ctl_if ctl ();

  typedef enum logic [1:0] {
    PS_IDLE  = 2'b01,
    PS_FIELD = 2'b10
  } bcec_ps_t;

  ////////////////////////////////////////////////////////////////////////////
  // state
  logic                  ren_m_q, ren_s_q;
  logic [ERR_W-1:0]      err_q, mask_q;
  logic                  slow_q, ack_q;
  logic [31:0]           dat_q;
  logic signed [12:0]    vsrc_q, pv_q;
  logic [15:0]           cal_q, pc_q;
  logic                  pvs_q, pcs_q, icmd_q, iopt_q, num_q;
  logic [3:0]            opt_q  [NLET];
  logic [3:0]            popt_q [NLET];
  logic [NLET-1:0]       pset_q;
  bcec_ps_t              ps_q;
  logic [4:0]            let_q;
  logic                  let_ok_q, neg_q, dot_q, ovf_q;
  logic [1:0]            fcnt_q;
  logic [23:0]           mag_q;

  ////////////////////////////////////////////////////////////////////////////
  // character decode
  wire        is_let   = rx_char_i >= 8'h41 && rx_char_i <= 8'h5a;
  wire        is_dig   = rx_char_i >= 8'h30 && rx_char_i <= 8'h39;
  wire        is_x     = rx_valid_i && rx_char_i == CH_X;
  wire        new_let  = rx_valid_i && is_let && !is_x;
  wire [4:0]  ch_idx   = rx_char_i[4:0] - 5'h01;
  wire        ch_ok    = LET_VALID[ch_idx];
  wire        close    = rx_valid_i && is_let && ps_q == PS_FIELD;
  wire        fld      = ps_q == PS_FIELD;
  wire        in_fld   = rx_valid_i && fld && !is_let;
  wire [23:0] mag_acc  = 24'(mag_q * 24'd10) + {20'h00000, rx_char_i[3:0]};

  ////////////////////////////////////////////////////////////////////////////
  // field close checks
  wire        is_v     = let_ok_q && let_q == LET_V;
  wire        is_c     = let_ok_q && let_q == LET_C;
  wire        is_o     = let_ok_q && !is_v && !is_c;
  wire [31:0] mag32    = {8'h00, mag_q};
  wire [31:0] scaled   = fcnt_q == 2'h0 ? 32'(mag32 * 32'd100) :
                         fcnt_q == 2'h1 ? 32'(mag32 * 32'd10) : mag32;
  wire        v_bad    = ovf_q || (neg_q ? scaled > VNEG_MAX : scaled > VPOS_MAX);
  wire [31:0] quo      = scaled / VSTEP;
  wire [12:0] step     = neg_q ? 13'(-quo[12:0]) : quo[12:0];
  wire        c_bad    = ovf_q || neg_q || dot_q || mag_q > CAL_MAX;
  wire        o_bad    = ovf_q || neg_q || dot_q || mag_q > {20'h00000, OPT_MAX[let_q]};
  wire        v_take   = close && is_v && !v_bad;
  wire        c_take   = close && is_c && !c_bad;
  wire        o_take   = close && is_o && !o_bad;

  ////////////////////////////////////////////////////////////////////////////
  // string totals including the field closed this cycle
  wire        w_icmd   = icmd_q || (new_let && !ch_ok);
  wire        w_iopt   = iopt_q || (close && is_o && o_bad);
  wire        w_num    = num_q || (close && ((is_v && v_bad) || (is_c && c_bad)));
  wire [12:0] w_pv     = v_take ? step : pv_q;
  wire [15:0] w_pc     = c_take ? mag_q[15:0] : pc_q;
  wire        w_pvs    = pvs_q || v_take;
  wire        w_pcs    = pcs_q || c_take;
  wire        no_rem   = is_x && !ren_s_q;
  wire        bus_err  = is_x && (no_rem || w_icmd || w_iopt);
  wire        num_err  = is_x && !bus_err && w_num;
  wire        commit   = is_x && !bus_err;
  wire        t_over   = trig_i && ctl.busy;
  wire [3:0]  w_popt [NLET];
  wire [NLET-1:0] w_pset;

  genvar gi;
  generate
    for (gi = 0; gi < NLET; gi++) begin : g_opt
      wire hit = o_take && let_q == 5'(gi);
      assign w_popt[gi] = hit ? mag_q[3:0] : popt_q[gi];
      assign w_pset[gi] = pset_q[gi] || hit;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // register bus decode
  wire        wb_req   = cyc_i && stb_i;
  wire        wb_wr    = wb_req && we_i && ack_q && sel_i[0];
  wire        wr_err   = wb_wr && adr_i == ADR_ERR;
  wire        wr_mask  = wb_wr && adr_i == ADR_MASK;
  wire        wr_ctrl  = wb_wr && adr_i == ADR_CTRL;
  wire [ERR_W-1:0] err_set = {num_err, t_over, no_rem, is_x && w_iopt,
                              is_x && w_icmd};
  wire [ERR_W-1:0] err_clr = wr_err ? dat_i[ERR_W-1:0] : '0;
  wire [31:0] state_w  = {24'h000000, trig_mode_o, ctl.msg, ctl.disp_on, ctl.busy};
  wire [31:0] rdata    = adr_i == ADR_ERR   ? {27'h0000000, err_q} :
                         adr_i == ADR_MASK  ? {27'h0000000, mask_q} :
                         adr_i == ADR_CTRL  ? {31'h00000000, slow_q} :
                         adr_i == ADR_VSRC  ? {{19{vsrc_q[12]}}, vsrc_q} :
                         adr_i == ADR_CAL   ? {16'h0000, cal_q} :
                         adr_i == ADR_STATE ? state_w : 32'h00000000;

  ////////////////////////////////////////////////////////////////////////////
  // bus slave, error word, mask, control
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q  <= 1'b0;
      dat_q  <= 32'h00000000;
      err_q  <= ERR_RST;
      mask_q <= MASK_RST;
      slow_q <= SLOW_RST;
    end else begin
      ack_q  <= wb_req && !ack_q;
      dat_q  <= (wb_req && !ack_q) ? rdata : dat_q;
      err_q  <= (err_q & ~err_clr) | err_set;
      mask_q <= wr_mask ? dat_i[ERR_W-1:0] : mask_q;
      slow_q <= wr_ctrl ? dat_i[CB_SLOW] : slow_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // remote enable synchroniser
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ren_m_q <= 1'b0;
      ren_s_q <= 1'b0;
    end else begin
      ren_m_q <= ren_i;
      ren_s_q <= ren_m_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // field parser
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ps_q     <= PS_IDLE;
      let_q    <= 5'h00;
      let_ok_q <= 1'b0;
      neg_q    <= 1'b0;
      dot_q    <= 1'b0;
      ovf_q    <= 1'b0;
      fcnt_q   <= 2'h0;
      mag_q    <= 24'h000000;
    end else begin
      case (ps_q)
        PS_IDLE, PS_FIELD: begin
          if (is_x) begin
            ps_q <= PS_IDLE;
          end else if (new_let) begin
            ps_q     <= PS_FIELD;
            let_q    <= ch_idx;
            let_ok_q <= ch_ok;
            neg_q    <= 1'b0;
            dot_q    <= 1'b0;
            ovf_q    <= 1'b0;
            fcnt_q   <= 2'h0;
            mag_q    <= 24'h000000;
          end else if (in_fld && is_dig && !ovf_q && (!dot_q || fcnt_q != 2'h2)) begin
            mag_q  <= mag_acc;
            ovf_q  <= mag_q >= MAG_OVF;
            fcnt_q <= dot_q ? fcnt_q + 2'h1 : fcnt_q;
          end else if (in_fld && rx_char_i == CH_DOT) begin
            dot_q <= 1'b1;
            ovf_q <= ovf_q || dot_q;
          end else if (in_fld && rx_char_i == CH_MINUS) begin
            neg_q <= 1'b1;
          end else if (in_fld && rx_char_i == CH_PLUS) begin
            neg_q <= neg_q;
          end
        end
        default: ps_q <= PS_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // string shadow and commit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vsrc_q <= VSRC_RST;
      cal_q  <= CAL_RST;
      pv_q   <= VSRC_RST;
      pc_q   <= CAL_RST;
      pvs_q  <= 1'b0;
      pcs_q  <= 1'b0;
      icmd_q <= 1'b0;
      iopt_q <= 1'b0;
      num_q  <= 1'b0;
      pset_q <= '0;
      for (int i = 0; i < NLET; i++) begin
        opt_q[i]  <= 4'h0;
        popt_q[i] <= 4'h0;
      end
    end else if (is_x) begin
      vsrc_q <= (commit && w_pvs) ? w_pv : vsrc_q;
      cal_q  <= (commit && w_pcs) ? w_pc : cal_q;
      pvs_q  <= 1'b0;
      pcs_q  <= 1'b0;
      icmd_q <= 1'b0;
      iopt_q <= 1'b0;
      num_q  <= 1'b0;
      pset_q <= '0;
      for (int i = 0; i < NLET; i++) begin
        opt_q[i] <= (commit && w_pset[i]) ? w_popt[i] : opt_q[i];
      end
    end else if (rx_valid_i) begin
      pv_q   <= w_pv;
      pc_q   <= w_pc;
      pvs_q  <= w_pvs;
      pcs_q  <= w_pcs;
      icmd_q <= w_icmd;
      iopt_q <= w_iopt;
      num_q  <= w_num;
      pset_q <= w_pset;
      for (int i = 0; i < NLET; i++) begin
        popt_q[i] <= w_popt[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // message and trigger requests
  assign ctl.show    = bus_err || num_err || t_over;
  assign ctl.msg_req = bus_err ? MSG_BUS : num_err ? MSG_NUM : MSG_TRIG;
  assign ctl.trig    = trig_i && !ctl.busy;
  assign ctl.slow    = slow_q;

  bcec_msg_timer #(
    .HOLD_CYC (DISP_CYC)
  ) u_msg (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ctl   (ctl)
  );

  bcec_ready_timer #(
    .FAST_CYC (FAST_CYC),
    .SLOW_CYC (SLOW_CYC)
  ) u_rdy (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ctl   (ctl)
  );

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign dat_o           = dat_q;
  assign ack_o           = ack_q;
  assign irq_o           = |(err_q & mask_q);
  assign disp_msg_o      = ctl.msg;
  assign disp_on_o       = ctl.disp_on;
  assign busy_o          = ctl.busy;
  assign reading_ready_o = ctl.ready;
  assign vsrc_step_o     = vsrc_q;
  assign cal_val_o       = cal_q;
  assign trig_mode_o     = opt_q[LET_T];
endmodule : bcec_checker

// *** test/bcec_checker_asserts.sv ***
// Purpose: port-level checks of the bus command error checker
// Assumes: one clock, synchronous active-high reset
// Notes:   bound to every bcec_checker instance
`timescale 1ns/10ps
module bcec_checker_asserts
  import bcec_pkg::*;
#(
  parameter int unsigned FAST_CYC = 10,
  parameter int unsigned SLOW_CYC = 15
) (
  input wire logic                clk_i,
  input wire logic                rst_i,
  input wire logic                cyc_i,
  input wire logic                stb_i,
  input wire logic                ack_o,
  input wire logic                rx_valid_i,
  input wire logic [7:0]          rx_char_i,
  input wire logic                trig_i,
  input wire logic                busy_o,
  input wire logic                reading_ready_o,
  input wire logic                disp_on_o,
  input wire bcec_pkg::bcec_msg_t disp_msg_o,
  input wire logic [3:0]          trig_mode_o,
  input wire logic signed [12:0]  vsrc_step_o,
  input wire logic [15:0]         cal_val_o
);
  logic        x_char;
  logic [31:0] bcnt_q;
  logic [31:0] bcnt_d;
  // busy cycle counter, restarted by an accepted trigger
  assign x_char = rx_valid_i && (rx_char_i == CH_X);
  assign bcnt_d = (trig_i && !busy_o) ? 32'h0 : (busy_o ? bcnt_q + 32'h1 : bcnt_q);
  always_ff @(posedge clk_i) begin
    bcnt_q <= rst_i ? 32'h0 : bcnt_d;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  //////////////////////////////////////////////////////////////////////////////
  ack_follows_req_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("ack missing after request");
  ack_one_cycle_a: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  busy_from_trig_a: assert property ($rose(busy_o) |-> $past(trig_i))
    else $error("busy rose without trigger");
  busy_length_a: assert property (reading_ready_o |-> !busy_o &&
    (bcnt_q == FAST_CYC || bcnt_q == SLOW_CYC)) else $error("busy length wrong");
  ready_on_fall_a: assert property ($fell(busy_o) |-> reading_ready_o)
    else $error("busy fell without ready");
  disp_matches_a: assert property (disp_on_o == (disp_msg_o != MSG_NONE))
    else $error("display flag and message disagree");
  disp_cause_a: assert property ($rose(disp_on_o) |-> $past(x_char || trig_i))
    else $error("message without terminator or trigger");
  overrun_shows_a: assert property (trig_i && busy_o |=> disp_on_o)
    else $error("overrun message missing");
  set_stable_a: assert property (!x_char |=>
    $stable({trig_mode_o, vsrc_step_o, cal_val_o})) else $error("settings moved");
  disp_holds_a: assert property ($rose(disp_on_o) |-> disp_on_o[*8])
    else $error("message dropped early");
  cover property ($rose(busy_o));
  cover property (trig_i && busy_o);
  cover property ($rose(disp_on_o) && disp_msg_o == MSG_NUM);
endmodule : bcec_checker_asserts

bind bcec_checker bcec_checker_asserts #(.FAST_CYC(FAST_CYC), .SLOW_CYC(SLOW_CYC)) chk_u (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
  .rx_valid_i(rx_valid_i), .rx_char_i(rx_char_i), .trig_i(trig_i), .busy_o(busy_o),
  .reading_ready_o(reading_ready_o), .disp_on_o(disp_on_o), .disp_msg_o(disp_msg_o),
  .trig_mode_o(trig_mode_o), .vsrc_step_o(vsrc_step_o), .cal_val_o(cal_val_o)
);

// *** test/bcec_host_model.sv ***
// Purpose: bus controller sending command strings and triggers
// Assumes: characters and triggers on the system clock
// Notes:   idle character lines show the inverse of the last character
`timescale 1ns/10ps
module bcec_host_model #(
  parameter int SETTLE_CYC = 8
) (
  input wire logic       clk_i,
  output logic           rx_valid_o,
  output logic     [7:0] rx_char_o,
  output logic           ren_o,
  output logic           trig_o
);
  initial begin
    rx_valid_o = 1'b0;
    rx_char_o  = 8'h00;
    ren_o      = 1'b0;
    trig_o     = 1'b0;
  end
  // remote level flips to its final value just before the terminator
  task automatic send(input string s, input logic r);
    ren_o <= !r;
    for (int i = 0; i < s.len(); i++) begin
      if (i == s.len() - 1) begin
        @(posedge clk_i);
        rx_valid_o <= 1'b0;
        rx_char_o  <= ~s[i-1];
        ren_o      <= r;
        repeat (2) @(posedge clk_i);
      end
      @(posedge clk_i);
      rx_valid_o <= 1'b1;
      rx_char_o  <= s[i];
    end
    @(posedge clk_i);
    rx_valid_o <= 1'b0;
    rx_char_o  <= ~s[s.len()-1];
  endtask : send
  task automatic trig();
    @(posedge clk_i);
    trig_o <= 1'b1;
    @(posedge clk_i);
    trig_o <= 1'b0;
  endtask : trig
  // wait for preamplifier settling before trusting readings
  task automatic settle();
    repeat (SETTLE_CYC) @(posedge clk_i);
  endtask : settle
endmodule : bcec_host_model

// *** test/bcec_checker_test.sv ***
// Purpose: self-checking bench of the bus command error checker
// Assumes: shortened display and reading counts
// Notes:   register reads first, then row table, triggers, masking, restart and reset
`timescale 1ns/10ps
module bcec_checker_test;
  import bcec_pkg::*;
  localparam int DISP = 20;
  localparam int FAST = 10;
  localparam int SLOW = 15;
  typedef struct {
    string cmd; logic ren; logic [4:0] err; bcec_msg_t msg;
    logic [3:0] tm; logic [12:0] vs; logic [15:0] cal;
  } bcec_row_t;
  bcec_row_t   rows [12];
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [7:0]  adr_i = 8'h00;
  logic [31:0] dat_i = 32'h0;
  logic        we_i = 1'b0;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic [31:0] dat_o, q;
  logic        ack_o, rx_valid_i, ren_i, trig_i, irq_o, disp_on_o, busy_o, reading_ready_o;
  logic [7:0]  rx_char_i;
  bcec_msg_t   disp_msg_o;
  logic signed [12:0] vsrc_step_o;
  logic [15:0] cal_val_o;
  logic [3:0]  trig_mode_o;
  int          mismatches = 0;
  int          checks = 0;
  int          disp_n = 0;
  int          bsy_n = 0;
  int          rdy_n = 0;
  int          base;
  int          rb;
  always #2 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    if (disp_on_o === 1'b1) disp_n <= disp_n + 1;
    if (busy_o === 1'b1) bsy_n <= bsy_n + 1;
    if (reading_ready_o === 1'b1) rdy_n <= rdy_n + 1;
  end
  bcec_checker #(.DISP_CYC(DISP), .FAST_CYC(FAST), .SLOW_CYC(SLOW)) dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o), .we_i(we_i),
    .sel_i(4'hf), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .rx_valid_i(rx_valid_i),
    .rx_char_i(rx_char_i), .ren_i(ren_i), .trig_i(trig_i), .irq_o(irq_o),
    .disp_msg_o(disp_msg_o), .disp_on_o(disp_on_o), .busy_o(busy_o),
    .reading_ready_o(reading_ready_o), .vsrc_step_o(vsrc_step_o), .cal_val_o(cal_val_o),
    .trig_mode_o(trig_mode_o));
  bcec_host_model host_u (.clk_i(clk_i), .rx_valid_o(rx_valid_i), .rx_char_o(rx_char_i),
    .ren_o(ren_i), .trig_o(trig_i));
  //////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : cmp
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] r);
    int n;
    @(posedge clk_i);
    cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a; dat_i <= d;
    n = 0;
    do begin @(posedge clk_i); n++; end while (ack_o !== 1'b1 && n < 50);
    r = dat_o;
    cyc_i <= 1'b0; stb_i <= 1'b0;
    if (ack_o !== 1'b1) begin mismatches++; end_sim(); end
  endtask : wb
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    rows = '{'{"T3X", 1, 5'h00, MSG_NONE, 4'h3, 13'h0000, 16'h0000},
             '{"H1X", 1, 5'h01, MSG_BUS, 4'h3, 13'h0000, 16'h0000},
             '{"T9X", 1, 5'h02, MSG_BUS, 4'h3, 13'h0000, 16'h0000},
             '{"T7X", 1, 5'h00, MSG_NONE, 4'h7, 13'h0000, 16'h0000},
             '{"T1X", 0, 5'h04, MSG_BUS, 4'h7, 13'h0000, 16'h0000},
             '{"D1V125X", 1, 5'h10, MSG_NUM, 4'h7, 13'h0000, 16'h0000},
             '{"V-102.35T3X", 1, 5'h00, MSG_NONE, 4'h3, 13'h1801, 16'h0000},
             '{"V-102.40X", 1, 5'h10, MSG_NUM, 4'h3, 13'h1801, 16'h0000},
             '{"V102.4X", 1, 5'h00, MSG_NONE, 4'h3, 13'h0800, 16'h0000},
             '{"V0.07X", 1, 5'h00, MSG_NONE, 4'h3, 13'h0001, 16'h0000},
             '{"C9999X", 1, 5'h00, MSG_NONE, 4'h3, 13'h0001, 16'h270f},
             '{"C10000T2X", 1, 5'h10, MSG_NUM, 4'h2, 13'h0001, 16'h270f}};
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      wb(1'b0, 8'(i * 4), 32'h0, q);
      cmp(q, 32'h0);
    end
    wb(1'b1, 8'h18, 32'h5, q);
    wb(1'b0, 8'h18, 32'h0, q);
    cmp(q, 32'h0);
    wb(1'b1, ADR_MASK, 32'h1f, q);
    wb(1'b0, ADR_MASK, 32'h0, q);
    cmp(q, 32'h1f);
    foreach (rows[i]) begin
      base = disp_n;
      host_u.send(rows[i].cmd, rows[i].ren);
      #1 cmp(disp_msg_o, rows[i].msg);
      repeat (DISP + 4) @(posedge clk_i);
      cmp(disp_n - base, rows[i].msg != MSG_NONE ? DISP : 0);
      wb(1'b0, ADR_ERR, 32'h0, q);
      cmp(q, rows[i].err);
      cmp(irq_o, rows[i].err != 5'h00);
      cmp(trig_mode_o, rows[i].tm);
      cmp({19'h0, vsrc_step_o}, rows[i].vs);
      cmp(cal_val_o, rows[i].cal);
      wb(1'b1, ADR_ERR, 32'h1f, q);
    end
    for (int s = 0; s < 2; s++) begin
      wb(1'b1, ADR_CTRL, 32'(s), q);
      base = bsy_n;
      rb = rdy_n;
      host_u.trig();
      repeat (3) @(posedge clk_i);
      host_u.trig();
      #1 cmp(disp_msg_o, MSG_TRIG);
      repeat (SLOW + 4) @(posedge clk_i);
      cmp(bsy_n - base, s ? SLOW : FAST);
      cmp(rdy_n - rb, 32'h1);
      wb(1'b0, ADR_ERR, 32'h0, q);
      cmp(q, 32'h08);
      wb(1'b1, ADR_ERR, 32'h1f, q);
      repeat (DISP) @(posedge clk_i);
    end
    host_u.settle();
    wb(1'b1, ADR_MASK, 32'h0, q);
    base = disp_n;
    host_u.send("H1X", 1'b1);
    repeat (10) @(posedge clk_i);
    host_u.send("H1X", 1'b1);
    #1 cmp(irq_o, 1'b0);
    repeat (DISP + 4) @(posedge clk_i);
    cmp(disp_n - base > DISP, 1'b1);
    wb(1'b1, ADR_MASK, 32'h1f, q);
    @(posedge clk_i);
    cmp(irq_o, 1'b1);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, ADR_ERR, 32'h0, q);
    cmp(q, 32'h0);
    cmp(trig_mode_o, 4'h0);
    end_sim();
  end
endmodule : bcec_checker_test
